/* rtl/tco_pkg.sv */
package tco_pkg;
  // ==========================================================
  // register map
  localparam int            TCO_ADDR_W     = 3;
  localparam int            TCO_DATA_W     = 8;
  localparam logic [2:0]    TCO_ADDR_CTRL  = 3'h0;
  localparam logic [2:0]    TCO_ADDR_COUNT = 3'h1;
  localparam logic [2:0]    TCO_ADDR_CMP   = 3'h2;
  localparam logic [2:0]    TCO_ADDR_FLAGS = 3'h3;

  // ==========================================================
  // field positions
  localparam int            TCO_CTRL_WAVE_LO  = 0;
  localparam int            TCO_CTRL_ACT_LO   = 2;
  localparam int            TCO_CTRL_FORCE    = 7;
  localparam int            TCO_FLAG_WRAP     = 0;
  localparam int            TCO_FLAG_MATCH    = 1;

  // ==========================================================
  // values
  localparam logic [7:0]    TCO_BOTTOM     = 8'h00;
  localparam logic [7:0]    TCO_MAX        = 8'hff;
  localparam logic [7:0]    TCO_ONE        = 8'h01;
  localparam logic [7:0]    TCO_ZERO_BYTE  = 8'h00;
  localparam logic [1:0]    TCO_WAVE_NORMAL = 2'h0;
  localparam logic [1:0]    TCO_WAVE_CTC    = 2'h2;
  localparam logic [1:0]    TCO_ACT_NONE    = 2'h0;
  localparam logic [1:0]    TCO_ACT_TOGGLE  = 2'h1;
  localparam logic [1:0]    TCO_ACT_CLEAR   = 2'h2;
  localparam logic [1:0]    TCO_ACT_SET     = 2'h3;
  localparam logic [1:0]    TCO_RST_WAVE    = 2'h0;
  localparam logic [1:0]    TCO_RST_ACT     = 2'h0;
  localparam logic          TCO_RST_OC      = 1'b0;

  typedef enum logic [1:0] {
    TCO_OC_KEEP,
    TCO_OC_TOGGLE,
    TCO_OC_CLEAR,
    TCO_OC_SET
  } tco_oc_op_e;
endpackage

/* rtl/tco_timer8.sv */
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - action field steers output register and pin
// - nonzero action field overrides port value
// - pin driven only when direction is output
// - override ignores waveform mode entirely
// - output register settable while pin disabled
// - action zero leaves output register unchanged
// - new action acts next match; force immediate
// - only wave mode shapes the count sequence
// - action means polarity in PWM, set/clear/toggle otherwise
// - normal mode always increments, wraps ff to 00
// - normal mode wrap flag set as count hits zero
// - counter writable at any time
// - clear-on-match mode clears counter at compare
// - unbuffered compare; low value misses until wrap
// - match flag raised at each compare match
// - toggle action inverts output every match
// - prescale factor comes from external tick source
// - clear-on-match wrap flag set at top to zero
// - fast PWM counts bottom to max, then bottom
// - fast PWM polarity: match and bottom edges
// - match flag set on the tick after equality
// - counter write blocks match at next tick
// - PWM compare buffered, transferred at bottom
// - forced match updates output only
module tco_timer8
  import tco_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  timer_tick_i,
  input  wire logic [TCO_ADDR_W-1:0] addr_i,
  input  wire logic [TCO_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [TCO_DATA_W-1:0] rdata_o,
  input  wire logic                  pin_direction_bit_i,
  input  wire logic                  port_value_i,
  output logic                       pin_o,
  output logic                       pin_oe_o,
  output logic                       wrap_flag_o,
  output logic                       match_flag_o
);

  // ==========================================================
  // state
  logic [1:0] wave_shape_select;
  logic [1:0] output_action_select;
  logic [7:0] count_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buf;
  logic       compare_output_bit;
  logic       wrap_flag;
  logic       match_flag;
  logic       match_block;

  // ==========================================================
  // decode
  wire        tick       = ce_i & timer_tick_i;
  wire        wr_ctrl    = ce_i & wr_i & (addr_i == TCO_ADDR_CTRL);
  wire        wr_count   = ce_i & wr_i & (addr_i == TCO_ADDR_COUNT);
  wire        wr_cmp     = ce_i & wr_i & (addr_i == TCO_ADDR_CMP);
  wire        wr_flags   = ce_i & wr_i & (addr_i == TCO_ADDR_FLAGS);
  wire        mode_pwm   = wave_shape_select[0];
  wire        mode_ctc   = (wave_shape_select == TCO_WAVE_CTC);
  wire        at_max     = (count_value == TCO_MAX);
  wire        eq_raw     = (count_value == compare_value);
  wire        match_hit  = tick & eq_raw & ~match_block;
  wire        ctc_clear  = mode_ctc & match_hit;
  wire        bottom_hit = tick & mode_pwm & at_max;
  wire        force_hit  = wr_ctrl & wdata_i[TCO_CTRL_FORCE] & ~mode_pwm;
  wire        wrap_hit   = tick & ~wr_count & (at_max | ctc_clear);

  // counting depends on the wave field only
  wire [7:0]  count_inc  = count_value + TCO_ONE;
  wire [7:0]  next_count = wr_count  ? wdata_i :
                           ctc_clear ? TCO_BOTTOM :
                           tick      ? count_inc : count_value;

  // ==========================================================
  // output register action
  function automatic tco_oc_op_e oc_op(input logic [1:0] act, input logic pwm,
                                       input logic bottom);
    tco_oc_op_e op;
    op = TCO_OC_KEEP;
    unique case (act)
      TCO_ACT_NONE:   op = TCO_OC_KEEP;
      TCO_ACT_TOGGLE: op = TCO_OC_TOGGLE;
      TCO_ACT_CLEAR:  op = (pwm && bottom) ? TCO_OC_SET : TCO_OC_CLEAR;
      TCO_ACT_SET:    op = (pwm && bottom) ? TCO_OC_CLEAR : TCO_OC_SET;
    endcase
    return op;
  endfunction

  function automatic logic oc_apply(input tco_oc_op_e op, input logic cur);
    logic r;
    r = cur;
    unique case (op)
      TCO_OC_KEEP:   r = cur;
      TCO_OC_TOGGLE: r = ~cur;
      TCO_OC_CLEAR:  r = 1'b0;
      TCO_OC_SET:    r = 1'b1;
    endcase
    return r;
  endfunction

  // match wins over bottom when both land in one tick, so compare at max
  // gives a steady level; toggle has no bottom edge in fast PWM
  wire        match_evt  = match_hit | force_hit;
  wire        bottom_evt = bottom_hit & ~match_hit &
                           (output_action_select != TCO_ACT_TOGGLE);
  wire        act_bottom = bottom_evt & ~match_evt;
  tco_oc_op_e op_sel;
  assign op_sel = oc_op(output_action_select, mode_pwm, act_bottom);
  wire        next_oc    = (match_evt | act_bottom) ?
                           oc_apply(op_sel, compare_output_bit) : compare_output_bit;

  // ==========================================================
  // pin override depends on the action field alone
  wire        override   = |output_action_select;
  assign pin_o    = override ? compare_output_bit : port_value_i;
  assign pin_oe_o = pin_direction_bit_i;
  assign wrap_flag_o  = wrap_flag;
  assign match_flag_o = match_flag;

  // ==========================================================
  // compare path: direct in non-PWM, buffered in PWM
  wire [7:0]  next_buf   = wr_cmp ? wdata_i : compare_buf;
  wire [7:0]  next_cmp   = (wr_cmp & ~mode_pwm) ? wdata_i :
                           bottom_hit ? compare_buf : compare_value;

  // ==========================================================
  // read mux; force bit always reads zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = TCO_ZERO_BYTE;
    unique case (addr_i)
      TCO_ADDR_CTRL: begin
        rd_mux[TCO_CTRL_WAVE_LO +: 2] = wave_shape_select;
        rd_mux[TCO_CTRL_ACT_LO +: 2]  = output_action_select;
      end
      TCO_ADDR_COUNT: rd_mux = count_value;
      TCO_ADDR_CMP:   rd_mux = compare_buf;
      TCO_ADDR_FLAGS: begin
        rd_mux[TCO_FLAG_WRAP]  = wrap_flag;
        rd_mux[TCO_FLAG_MATCH] = match_flag;
      end
      default:        rd_mux = TCO_ZERO_BYTE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave_shape_select    <= TCO_RST_WAVE;
      output_action_select <= TCO_RST_ACT;
      compare_output_bit   <= TCO_RST_OC;
      count_value          <= TCO_BOTTOM;
      compare_value        <= TCO_BOTTOM;
      compare_buf          <= TCO_BOTTOM;
      match_block          <= 1'b0;
      rdata_o              <= TCO_ZERO_BYTE;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        wave_shape_select    <= wdata_i[TCO_CTRL_WAVE_LO +: 2];
        output_action_select <= wdata_i[TCO_CTRL_ACT_LO +: 2];
      end
      compare_output_bit <= next_oc;
      count_value        <= next_count;
      compare_value      <= next_cmp;
      compare_buf        <= next_buf;
      // block holds even while the tick is stopped
      match_block        <= wr_count | (match_block & ~tick);
      rdata_o            <= rd_i ? rd_mux : TCO_ZERO_BYTE;
    end
  end

  // flags: write one clears, a hardware set in the same cycle wins
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wrap_flag  <= 1'b0;
      match_flag <= 1'b0;
    end else if (ce_i) begin
      wrap_flag  <= wrap_hit |
                    (wrap_flag & ~(wr_flags & wdata_i[TCO_FLAG_WRAP]));
      match_flag <= match_hit |
                    (match_flag & ~(wr_flags & wdata_i[TCO_FLAG_MATCH]));
    end
  end

  // ==========================================================
  // checks
  property p_normal_inc;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && !wr_count && wave_shape_select == TCO_WAVE_NORMAL)
      |=> (count_value == 8'($past(count_value) + TCO_ONE));
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("normal count step wrong");

  property p_wrap_normal;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && !wr_count && at_max && !mode_ctc) |=> (wrap_flag && count_value == TCO_BOTTOM);
  endproperty
  a_wrap_normal: assert property (p_wrap_normal) else $error("wrap flag missing");

  property p_ctc_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && mode_ctc && eq_raw && !match_block && !wr_count)
      |=> (count_value == TCO_BOTTOM && match_flag && wrap_flag);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear wrong");

  property p_block;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && eq_raw && match_block && !match_flag) |=> !match_flag;
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag");

  property p_force;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (force_hit && !tick && !match_flag && !wr_count)
      |=> (!match_flag && $stable(count_value));
  endproperty
  a_force: assert property (p_force) else $error("force touched flag or count");

  property p_act_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && output_action_select == TCO_ACT_NONE) |=> $stable(compare_output_bit);
  endproperty
  a_act_zero: assert property (p_act_zero) else $error("output moved with no action");

  property p_override;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (output_action_select != TCO_ACT_NONE) |-> (pin_o == compare_output_bit);
  endproperty
  a_override: assert property (p_override) else $error("pin not from output register");

  property p_pwm_match;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (match_hit && mode_pwm && output_action_select == TCO_ACT_CLEAR) |=> !compare_output_bit;
  endproperty
  a_pwm_match: assert property (p_pwm_match) else $error("pwm match edge wrong");

  property p_pwm_bottom;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (bottom_hit && !match_hit && output_action_select == TCO_ACT_SET) |=> !compare_output_bit;
  endproperty
  a_pwm_bottom: assert property (p_pwm_bottom) else $error("pwm bottom edge wrong");

  property p_pwm_buf;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && mode_pwm && wr_cmp && !bottom_hit) |=> $stable(compare_value);
  endproperty
  a_pwm_buf: assert property (p_pwm_buf) else $error("pwm compare not buffered");

  // ==========================================================
  // block, flag, pin, output bit and count checks
  property p_block_arm;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_count |=> match_block;
  endproperty
  a_block_arm: assert property (p_block_arm) else $error("counter write did not arm block");

  // the block must not outlive its first tick, or later matches vanish
  property p_block_end;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && !wr_count) |=> !match_block;
  endproperty
  a_block_end: assert property (p_block_end) else $error("block outlived its tick");

  property p_match_set;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    match_hit |=> match_flag;
  endproperty
  a_match_set: assert property (p_match_set) else $error("match flag not set");

  property p_match_only;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && !match_hit && !match_flag) |=> !match_flag;
  endproperty
  a_match_only: assert property (p_match_only) else $error("match flag set without match");

  property p_override_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (output_action_select == TCO_ACT_NONE) |-> (pin_o == port_value_i);
  endproperty
  a_override_off: assert property (p_override_off) else $error("port value lost");

  property p_pwm_inc;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && mode_pwm && !at_max && !wr_count)
      |=> (count_value == 8'($past(count_value) + TCO_ONE));
  endproperty
  a_pwm_inc: assert property (p_pwm_inc) else $error("fast pwm count step wrong");

  property p_ctc_run;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tick && mode_ctc && !eq_raw && !wr_count)
      |=> (count_value == 8'($past(count_value) + TCO_ONE));
  endproperty
  a_ctc_run: assert property (p_ctc_run) else $error("clear-on-match count step wrong");

  property p_ctc_toggle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ctc_clear && output_action_select == TCO_ACT_TOGGLE)
      |=> (compare_output_bit != $past(compare_output_bit));
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("toggle on match missing");

  property p_nonpwm_set;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (match_evt && !mode_pwm && output_action_select == TCO_ACT_SET)
      |=> compare_output_bit;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("set action did not set");

  property p_nonpwm_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (match_evt && !mode_pwm && output_action_select == TCO_ACT_CLEAR)
      |=> !compare_output_bit;
  endproperty
  a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("clear action did not clear");

  property p_force_pwm;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_ctrl && wdata_i[TCO_CTRL_FORCE] && mode_pwm && !tick)
      |=> $stable(compare_output_bit);
  endproperty
  a_force_pwm: assert property (p_force_pwm) else $error("force acted in pwm mode");

  // a prescaler that gates ce_i relies on every state bit holding still
  property p_frozen;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ce_i |=> ($stable(count_value) && $stable(compare_output_bit) &&
               $stable(wrap_flag) && $stable(match_flag));
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved with clock enable low");

  c_ctc_toggle: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ctc_clear && output_action_select == TCO_ACT_TOGGLE);
  c_pwm_bottom: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bottom_hit && output_action_select == TCO_ACT_CLEAR);
  c_force: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) force_hit);
  c_pwm_match: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    match_hit && mode_pwm);
  c_block: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tick && eq_raw && match_block);

endmodule

/* bench/tco_pin_load.sv */
`timescale 1ns/1ps
// ==========================================================
// external load on the compare output pin
module tco_pin_load #(
  parameter logic PULL_LEVEL = 1'b0
) (
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      pad_o
);
  // undriven pad falls to the pull level, never a stale value
  assign pad_o = oe_i ? pin_i : PULL_LEVEL;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import tco_pkg::*;
;
  typedef struct {
    logic [1:0] wave;
    logic [1:0] act;
    logic [7:0] start;
    logic [7:0] cmp;
    int         n;
    logic       port;
    logic [7:0] cnt;
    logic [7:0] flg;
    logic       pin;
  } tco_row_s;

  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       ce_i = 1'b1;
  logic       timer_tick_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       pin_direction_bit_i = 1'b1;
  logic       port_value_i = 1'b0;
  logic       pin_o;
  logic       pin_oe_o;
  logic       wrap_flag_o;
  logic       match_flag_o;
  logic       pad;
  logic [7:0] d;
  int         num_errors = 0;
  int         comparisons = 0;
  tco_row_s   rows [6];

  always #25 core_clk_i = ~core_clk_i;

  tco_timer8 dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .timer_tick_i(timer_tick_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_direction_bit_i(pin_direction_bit_i), .port_value_i(port_value_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .wrap_flag_o(wrap_flag_o),
    .match_flag_o(match_flag_o)
  );

  tco_pin_load load_u (.pin_i(pin_o), .oe_i(pin_oe_o), .pad_o(pad));

  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // tick held high gives one tick per clock, prescale of one
  task automatic ticks(input int n);
    @(posedge core_clk_i);
    timer_tick_i <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    timer_tick_i <= 1'b0;
  endtask

  // one-cycle tick pulse every div clocks, as a prescaler would give
  task automatic slow_ticks(input int n, input int div);
    repeat (n) begin
      repeat (div - 1) @(posedge core_clk_i);
      timer_tick_i <= 1'b1;
      @(posedge core_clk_i);
      timer_tick_i <= 1'b0;
    end
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    rows[0] = '{2'h0, 2'h1, 8'h00, 8'h05, 10, 1'b0, 8'h0a, 8'h02, 1'b1};
    rows[1] = '{2'h2, 2'h1, 8'h00, 8'h03, 10, 1'b0, 8'h02, 8'h03, 1'b0};
    rows[2] = '{2'h2, 2'h3, 8'h00, 8'h02, 3, 1'b0, 8'h00, 8'h03, 1'b1};
    rows[3] = '{2'h0, 2'h0, 8'h00, 8'h01, 3, 1'b1, 8'h03, 8'h02, 1'b1};
    rows[4] = '{2'h1, 2'h2, 8'hfd, 8'h01, 5, 1'b0, 8'h02, 8'h03, 1'b0};
    rows[5] = '{2'h1, 2'h3, 8'hfd, 8'h01, 5, 1'b0, 8'h02, 8'h03, 1'b1};
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      // clear output bit first: force uses the action held before the write
      wr(TCO_ADDR_CTRL, 8'h08);
      wr(TCO_ADDR_CTRL, 8'h88);
      wr(TCO_ADDR_COUNT, rows[i].start);
      wr(TCO_ADDR_FLAGS, 8'h03);
      wr(TCO_ADDR_CMP, rows[i].cmp);
      port_value_i <= rows[i].port;
      wr(TCO_ADDR_CTRL, {4'h0, rows[i].act, rows[i].wave});
      ticks(rows[i].n);
      rd(TCO_ADDR_COUNT, d);
      chk(d, rows[i].cnt);
      rd(TCO_ADDR_FLAGS, d);
      chk(d, rows[i].flg);
      chk({7'h0, pin_o}, {7'h0, rows[i].pin});
      chk({6'h0, match_flag_o, wrap_flag_o}, rows[i].flg);
    end
    // ==========================================================
    // reset in mid-run
    @(posedge core_clk_i);
    port_value_i <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(TCO_ADDR_CTRL, d);
    chk(d, 8'h00);
    chk({7'h0, pin_o}, 8'h00);
    // preset output bit while the pin is an input
    @(posedge core_clk_i);
    pin_direction_bit_i <= 1'b0;
    wr(TCO_ADDR_CTRL, 8'h0c);
    wr(TCO_ADDR_CTRL, 8'h8c);
    #1;
    chk({7'h0, pad}, 8'h00);
    rd(TCO_ADDR_FLAGS, d);
    chk(d, 8'h00);
    @(posedge core_clk_i);
    pin_direction_bit_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({7'h0, pad}, 8'h01);
    // counter write blocks the next match; ticks with ce low do nothing
    wr(TCO_ADDR_CMP, 8'h10);
    wr(TCO_ADDR_COUNT, 8'h10);
    ce_i <= 1'b0;
    ticks(3);
    ce_i <= 1'b1;
    ticks(1);
    rd(TCO_ADDR_COUNT, d);
    chk(d, 8'h11);
    rd(TCO_ADDR_FLAGS, d);
    chk(d, 8'h00);
    wr(TCO_ADDR_COUNT, 8'h0f);
    ticks(2);
    rd(TCO_ADDR_FLAGS, d);
    chk(d, 8'h02);
    // clear-on-match with compare below count runs through the wrap
    wr(TCO_ADDR_CTRL, 8'h02);
    wr(TCO_ADDR_COUNT, 8'h20);
    wr(TCO_ADDR_FLAGS, 8'h03);
    wr(TCO_ADDR_CMP, 8'h05);
    ticks(229);
    rd(TCO_ADDR_COUNT, d);
    chk(d, 8'h05);
    rd(TCO_ADDR_FLAGS, d);
    chk(d, 8'h01);
    ticks(1);
    rd(TCO_ADDR_COUNT, d);
    chk(d, 8'h00);
    // unmapped place reads zero and ignores writes
    wr(3'h6, 8'hff);
    rd(3'h5, d);
    chk(d, 8'h00);
    rd(TCO_ADDR_CTRL, d);
    chk(d, 8'h02);
    // fast PWM: a compare write waits in the buffer until max
    wr(TCO_ADDR_CTRL, 8'h09);
    wr(TCO_ADDR_FLAGS, 8'h03);
    wr(TCO_ADDR_COUNT, 8'h04);
    wr(TCO_ADDR_CMP, 8'h06);
    slow_ticks(2, 8);
    rd(TCO_ADDR_COUNT, d);
    chk(d, 8'h06);
    rd(TCO_ADDR_FLAGS, d);
    chk(d, 8'h02);
    rd(TCO_ADDR_CMP, d);
    chk(d, 8'h06);
    chk({7'h0, pin_o}, 8'h00);
    // force is ignored in PWM modes
    wr(TCO_ADDR_CTRL, 8'h05);
    wr(TCO_ADDR_CTRL, 8'h85);
    #1;
    chk({7'h0, pin_o}, 8'h00);
    finish_test();
  end
endmodule
